//--- inc/port_cfg_pkg.sv
// constants and carrier types for the interconnect port configuration register bank
// assumes an avalon-mm slave with 32-bit data and byte addressing
package port_cfg_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int BLK_SEL_W = 4;
   // slave-side interface block offsets
   localparam logic [ADDR_W-1:0] OFS_SLAVE_READ_PRIORITY  = 12'h100;
   localparam logic [ADDR_W-1:0] OFS_SLAVE_WRITE_PRIORITY = 12'h104;
   localparam logic [ADDR_W-1:0] OFS_SLAVE_ISSUE_LIMIT    = 12'h108;
   // internal interface block offsets
   localparam logic [ADDR_W-1:0] OFS_IB_SWITCH_ISSUE      = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_IB_CLOCK_CROSSING    = 12'h020;
   // widths
   localparam int PRIORITY_W = 4;
   localparam int ISSUE_W = 2;
   localparam int CROSSING_W = 3;
   // field positions
   localparam int ISSUE_READ_BIT = 0;
   localparam int ISSUE_WRITE_BIT = 1;
   // reset values
   localparam logic [3:0] RST_PRIORITY = 4'h0;
   localparam logic [1:0] RST_ISSUE = 2'h0;
   localparam logic [2:0] RST_CROSSING = 3'h4;

   typedef enum logic [2:0] {
      CROSS_SYNC_1_1 = 3'b000,
      CROSS_SYNC_M_1 = 3'b001,
      CROSS_SYNC_1_N = 3'b010,
      CROSS_SYNC_M_N = 3'b011,
      CROSS_ASYNC    = 3'b100
   } crossing_mode_type;

   typedef struct packed {
      logic       read_one;
      logic       write_one;
   } issue_limit_type;

   typedef struct packed {
      logic [3:0]      read_priority;
      logic [3:0]      write_priority;
      issue_limit_type issue_limit;
   } slave_cfg_type;

   typedef struct packed {
      issue_limit_type   switch_issue;
      crossing_mode_type crossing;
   } ib_cfg_type;
endpackage

//--- logic/port_cfg_regs.sv
// register bank: one slave-side interface block page and NUM_IB internal block pages
// assumes an avalon-mm master keeping read and write exclusive; config outputs feed the datapath on mclk
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module port_cfg_regs #(
   parameter int         NUM_IB            = 2,
   parameter bit         PRIORITY_PROG     = 1'b1,
   parameter logic [3:0] READ_PRIORITY_RST  = port_cfg_pkg::RST_PRIORITY,
   parameter logic [3:0] WRITE_PRIORITY_RST = port_cfg_pkg::RST_PRIORITY,
   parameter bit         CROSSING_PROG     = 1'b1
) (
   // clock and reset
   input  wire logic                                         mclk,
   input  wire logic                                         rst,
   // avalon-mm slave
   input  wire logic [port_cfg_pkg::BLK_SEL_W+port_cfg_pkg::ADDR_W-1:0] address,
   input  wire logic                                         read,
   input  wire logic                                         write,
   input  wire logic [3:0]                                   byteenable,
   input  wire logic [port_cfg_pkg::DATA_W-1:0]              writedata,
   output logic      [port_cfg_pkg::DATA_W-1:0]              readdata,
   output logic                                              waitrequest,
   // configuration to the datapath
   output port_cfg_pkg::slave_cfg_type                       slave_cfg,
   output port_cfg_pkg::ib_cfg_type [NUM_IB-1:0]             ib_cfg
);
   localparam int AW = port_cfg_pkg::ADDR_W;
   localparam int PW = port_cfg_pkg::BLK_SEL_W;
   localparam int DW = port_cfg_pkg::DATA_W;
   localparam int QW = port_cfg_pkg::PRIORITY_W;
   localparam int IW = port_cfg_pkg::ISSUE_W;

   // build-time checks: refuse options that the page decode and the read mux cannot serve
   if (NUM_IB < 1) begin : gen_chk_ib_low
      $error("NUM_IB must be at least 1");
   end
   if (NUM_IB > (1 << PW) - 1) begin : gen_chk_ib_high
      $error("NUM_IB exceeds the pages that the address can select");
   end
   if (DW < QW || DW < IW) begin : gen_chk_data
      $error("data bus narrower than a register field");
   end
   if (port_cfg_pkg::ISSUE_READ_BIT >= IW || port_cfg_pkg::ISSUE_WRITE_BIT >= IW) begin : gen_chk_bits
      $error("issue override bit positions lie outside the register");
   end
   if (port_cfg_pkg::OFS_SLAVE_READ_PRIORITY == port_cfg_pkg::OFS_SLAVE_ISSUE_LIMIT) begin : gen_chk_ofs
      $error("slave-side offsets overlap");
   end
   if ($bits(port_cfg_pkg::slave_cfg_type) != 2 * QW + IW) begin : gen_chk_carrier
      $error("slave configuration carrier does not match the field widths");
   end

   // address split: page 0 is the slave-side block, page k is internal block k-1
   wire logic [PW-1:0] page     = address[PW+AW-1:AW];
   wire logic [AW-1:0] ofs      = address[AW-1:0];
   wire logic          is_slave = (page == PW'(0));

   // avalon handshake: exactly one wait state per access, writes land in the answer cycle
   logic      ack_r;
   logic      ack_nxt;
   wire logic req      = read | write;
   wire logic first    = req & ~ack_r;
   wire logic do_write = write & ack_r;
   wire logic wr_lane0 = do_write & byteenable[0];
   // read data is latched at the request edge so that it already stands when the
   // master samples waitrequest low; this relies on the address being held meanwhile
   wire logic rd_load  = read & ~ack_r;

   assign waitrequest = first;
   assign ack_nxt     = first;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
      end
   end

   // slave-side decode; the priority offsets vanish when priority is fixed at build time
   wire logic prio_here = is_slave & PRIORITY_PROG;
   wire logic hit_rprio = prio_here & (ofs == port_cfg_pkg::OFS_SLAVE_READ_PRIORITY);
   wire logic hit_wprio = prio_here & (ofs == port_cfg_pkg::OFS_SLAVE_WRITE_PRIORITY);
   wire logic hit_slim  = is_slave & (ofs == port_cfg_pkg::OFS_SLAVE_ISSUE_LIMIT);

   wire logic wr_rprio  = wr_lane0 & hit_rprio;
   wire logic wr_wprio  = wr_lane0 & hit_wprio;
   wire logic wr_slim   = wr_lane0 & hit_slim;

   // reset value is the zero default unless built as programmable with a chosen value
   localparam logic [QW-1:0] RPRIO_RST = PRIORITY_PROG ? READ_PRIORITY_RST : port_cfg_pkg::RST_PRIORITY;
   localparam logic [QW-1:0] WPRIO_RST = PRIORITY_PROG ? WRITE_PRIORITY_RST : port_cfg_pkg::RST_PRIORITY;

   logic [QW-1:0] rprio_r;
   logic [QW-1:0] wprio_r;
   logic [IW-1:0] slim_r;

   cfg_field #(
      .WIDTH     (QW),
      .RST_VALUE (RPRIO_RST)
   ) rprio_field (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (wr_rprio),
      .wr_data (writedata[QW-1:0]),
      .value   (rprio_r)
   );

   cfg_field #(
      .WIDTH     (QW),
      .RST_VALUE (WPRIO_RST)
   ) wprio_field (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (wr_wprio),
      .wr_data (writedata[QW-1:0]),
      .value   (wprio_r)
   );

   cfg_field #(
      .WIDTH     (IW),
      .RST_VALUE (port_cfg_pkg::RST_ISSUE)
   ) slim_field (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (wr_slim),
      .wr_data (writedata[IW-1:0]),
      .value   (slim_r)
   );

   assign slave_cfg = '{
      read_priority:  rprio_r,
      write_priority: wprio_r,
      issue_limit:    '{
         read_one:  slim_r[port_cfg_pkg::ISSUE_READ_BIT],
         write_one: slim_r[port_cfg_pkg::ISSUE_WRITE_BIT]
      }
   };

   // one register copy per internal block, each decoding its own page
   logic [NUM_IB-1:0][DW-1:0] ib_rd;

   for (genvar g = 0; g < NUM_IB; g++) begin : gen_ib
      wire logic sel = (page == PW'(g + 1));

      ib_page_regs #(
         .CROSSING_PROG (CROSSING_PROG)
      ) page_regs (
         .mclk      (mclk),
         .rst       (rst),
         .sel       (sel),
         .ofs       (ofs),
         .wr_lane0  (wr_lane0),
         .writedata (writedata),
         .rd_word   (ib_rd[g]),
         .cfg       (ib_cfg[g])
      );
   end

   // pages are exclusive, so or-ing the copies yields the selected one
   logic [DW-1:0] ib_rd_any;
   always_comb begin
      ib_rd_any = '0;
      for (int i = 0; i < NUM_IB; i++) begin
         ib_rd_any = ib_rd_any | ib_rd[i];
      end
   end

   // anything unmapped, absent or on a missing page reads as zero and takes no write
   wire logic [DW-1:0] slave_rd = hit_rprio ? DW'(rprio_r) :
                                  hit_wprio ? DW'(wprio_r) :
                                  hit_slim  ? DW'(slim_r)  : '0;
   wire logic [DW-1:0] rd_sel   = is_slave ? slave_rd : ib_rd_any;

   // read data holds until the next read, so a slow master may still look at it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         readdata <= '0;
      end else if (rd_load) begin
         readdata <= rd_sel;
      end
   end
endmodule

// one internal block page: switch issue override and clock-crossing selector
module ib_page_regs #(
   parameter bit CROSSING_PROG = 1'b1
) (
   // clock and reset
   input  wire logic                            mclk,
   input  wire logic                            rst,
   // decoded access from the bank
   input  wire logic                            sel,
   input  wire logic [port_cfg_pkg::ADDR_W-1:0] ofs,
   input  wire logic                            wr_lane0,
   input  wire logic [port_cfg_pkg::DATA_W-1:0] writedata,
   // read word and configuration of this block
   output logic      [port_cfg_pkg::DATA_W-1:0] rd_word,
   output port_cfg_pkg::ib_cfg_type             cfg
);
   localparam int DW = port_cfg_pkg::DATA_W;
   localparam int IW = port_cfg_pkg::ISSUE_W;
   localparam int CW = port_cfg_pkg::CROSSING_W;

   if (port_cfg_pkg::RST_CROSSING > CW'(port_cfg_pkg::CROSS_ASYNC)) begin : gen_chk_rst
      $error("crossing reset value is a reserved code");
   end
   if (port_cfg_pkg::OFS_IB_SWITCH_ISSUE == port_cfg_pkg::OFS_IB_CLOCK_CROSSING) begin : gen_chk_ofs
      $error("internal block offsets overlap");
   end
   if ($bits(port_cfg_pkg::ib_cfg_type) != IW + CW) begin : gen_chk_carrier
      $error("internal block carrier does not match the field widths");
   end

   wire logic hit_iss   = sel & (ofs == port_cfg_pkg::OFS_IB_SWITCH_ISSUE);
   wire logic hit_cross = sel & CROSSING_PROG & (ofs == port_cfg_pkg::OFS_IB_CLOCK_CROSSING);
   // reserved codes are refused so the datapath never sees an undefined scheme
   wire logic code_ok   = (writedata[CW-1:0] <= CW'(port_cfg_pkg::CROSS_ASYNC));

   wire logic wr_iss    = wr_lane0 & hit_iss;
   wire logic wr_cross  = wr_lane0 & hit_cross & code_ok;

   logic [IW-1:0] iss_r;
   logic [CW-1:0] cross_r;

   cfg_field #(
      .WIDTH     (IW),
      .RST_VALUE (port_cfg_pkg::RST_ISSUE)
   ) iss_field (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (wr_iss),
      .wr_data (writedata[IW-1:0]),
      .value   (iss_r)
   );

   cfg_field #(
      .WIDTH     (CW),
      .RST_VALUE (port_cfg_pkg::RST_CROSSING)
   ) cross_field (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (wr_cross),
      .wr_data (writedata[CW-1:0]),
      .value   (cross_r)
   );

   assign cfg = '{
      switch_issue: '{
         read_one:  iss_r[port_cfg_pkg::ISSUE_READ_BIT],
         write_one: iss_r[port_cfg_pkg::ISSUE_WRITE_BIT]
      },
      crossing:     port_cfg_pkg::crossing_mode_type'(cross_r)
   };

   assign rd_word = hit_iss   ? DW'(iss_r)   :
                    hit_cross ? DW'(cross_r) : '0;
endmodule

// one read-write field: loads on a qualified write, otherwise holds
module cfg_field #(
   parameter int               WIDTH     = 4,
   parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // write port
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   // stored value
   output logic      [WIDTH-1:0] value
);
   if (WIDTH < 1) begin : gen_chk_width
      $error("a field needs at least one bit");
   end

   logic      [WIDTH-1:0] value_r;
   wire logic [WIDTH-1:0] value_nxt = wr_en ? wr_data : value_r;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         value_r <= RST_VALUE;
      end else begin
         value_r <= value_nxt;
      end
   end

   assign value = value_r;
endmodule

//--- tb/port_cfg_regs_checker.sv
// checker: access timing and register field updates of the config bank
// assumes the default page layout, page 0 slave side, page k internal block k-1
`timescale 1ns/1ps
module port_cfg_regs_checker #(parameter int NUM_IB = 2) (
   input wire logic                        mclk, rst, read, write, waitrequest,
   input wire logic [15:0]                 address,
   input wire logic [3:0]                  byteenable,
   input wire logic [31:0]                 writedata, readdata,
   input wire port_cfg_pkg::slave_cfg_type slave_cfg,
   input wire port_cfg_pkg::ib_cfg_type    [NUM_IB-1:0] ib_cfg
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire wr_done = write && !waitrequest && byteenable[0];
   AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("wait state count wrong");
   AST_READ_PRIO: assert property (wr_done && address == 16'h0100 |=> slave_cfg.read_priority == $past(writedata[3:0]))
      else $error("read priority not written");
   AST_WRITE_PRIO: assert property (wr_done && address == 16'h0104 |=> slave_cfg.write_priority == $past(writedata[3:0]))
      else $error("write priority not written");
   AST_ISSUE: assert property (wr_done && address == 16'h0108 |=> slave_cfg.issue_limit == {$past(writedata[0]), $past(writedata[1])})
      else $error("issue limit bits wrong");
   AST_SWITCH: assert property (wr_done && address == 16'h1008 |=> ib_cfg[0].switch_issue == {$past(writedata[0]), $past(writedata[1])})
      else $error("switch override bits wrong");
   AST_CROSS: assert property (wr_done && address == 16'h1020 && writedata[2:0] < 3'h5 |=> ib_cfg[0].crossing == $past(writedata[2:0]))
      else $error("crossing select not written");
   AST_CROSS_RSV: assert property (wr_done && address == 16'h1020 && writedata[2:0] > 3'h4 |=> $stable(ib_cfg[0].crossing))
      else $error("reserved crossing code taken");
   AST_COPY: assert property (write && address[15:12] == 4'h1 |=> $stable(ib_cfg[1]))
      else $error("block copies not separate");
   AST_RSV_READ: assert property (read && !waitrequest && address[11:0] == 12'h10C |-> readdata == 32'h0)
      else $error("reserved offset read nonzero");
   COV_CROSS: cover property (wr_done && address == 16'h1020);
   COV_ISSUE: cover property (wr_done && address == 16'h0108);
   COV_RSV: cover property (read && !waitrequest && address[11:0] == 12'h10C);
endmodule
bind port_cfg_regs port_cfg_regs_checker #(.NUM_IB(NUM_IB)) chk (.mclk(mclk), .rst(rst), .read(read), .write(write),
   .waitrequest(waitrequest), .address(address), .byteenable(byteenable), .writedata(writedata),
   .readdata(readdata), .slave_cfg(slave_cfg), .ib_cfg(ib_cfg));

//--- tb/port_cfg_regs_test.sv
// testbench: random avalon-mm traffic checked against a reference register map
// assumes port_cfg_regs with two internal blocks and default build options
`timescale 1ns/1ps
module port_cfg_regs_test;
   logic        mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, waitrequest;
   logic [15:0] address = 16'h0;
   logic [3:0]  byteenable = 4'h0;
   logic [31:0] writedata = 32'h0, readdata;
   port_cfg_pkg::slave_cfg_type     slave_cfg;
   port_cfg_pkg::ib_cfg_type [1:0]  ib_cfg;
   int bad_count = 0, checked = 0;
   int m[int] = '{16'h0100:0, 16'h0104:0, 16'h0108:0, 16'h1008:0, 16'h1020:4, 16'h2008:0, 16'h2020:4};
   int mk[int] = '{16'h0100:15, 16'h0104:15, 16'h0108:3, 16'h1008:3, 16'h1020:7, 16'h2008:3, 16'h2020:7};
   int pick[10] = '{16'h0100, 16'h0104, 16'h0108, 16'h1008, 16'h1020, 16'h2008, 16'h2020, 16'h010C, 16'h1000, 16'h3008};
   port_cfg_regs dut (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .slave_cfg(slave_cfg), .ib_cfg(ib_cfg));
   always #2.5 mclk = ~mclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [31:0] cfg_exp();
      return {12'h0, m[16'h0100][3:0], m[16'h0104][3:0], m[16'h0108][0], m[16'h0108][1], m[16'h2008][0],
              m[16'h2008][1], m[16'h2020][2:0], m[16'h1008][0], m[16'h1008][1], m[16'h1020][2:0]};
   endfunction
   // read data stands at the edge where waitrequest is sampled low and is taken there
   task automatic bus(input bit w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] rd;
      @(posedge mclk);
      address <= a; read <= !w; write <= w; writedata <= d; byteenable <= be;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0; write <= 1'b0;
      if (w && be[0] && m.exists(a) && !(a[11:0] == 12'h020 && d[2:0] > 3'h4)) m[a] = d & mk[a];
      #1;
      if (!w) check(rd, m.exists(a) ? m[a] : 32'h0);
      check(32'({slave_cfg, ib_cfg}), cfg_exp());
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      conclude();
   end
   initial begin
      logic [15:0] a;
      void'($urandom(32'h7385));
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      foreach (mk[k]) bus(1'b0, k[15:0], 32'h0, 4'hF);
      for (int c = 0; c < 8; c++) bus(1'b1, 16'h1020, 32'(c), 4'h1);
      bus(1'b1, 16'h0104, 32'hFFFF_FFFF, 4'hE);
      repeat (150) begin
         a = pick[$urandom_range(9)];
         bus(1'($urandom_range(1)), a, $urandom, 4'($urandom));
      end
      conclude();
   end
endmodule
